// ==== hdl/disk_fmt_consts.vh ====
/*
 * Constants for the disk sector format sequencer: register offsets,
 * field positions, reset values, byte patterns and field lengths.
 * Assumes it is included by the sequencer module and the bench; definitions only.
 */
`ifndef DISK_FMT_CONSTS_VH
`define DISK_FMT_CONSTS_VH

// ==========================================================
// Register byte offsets
`define REG_CTRL      8'h00
`define REG_STAT      8'h04
`define REG_MASK      8'h08
`define REG_FILL      8'h0c
`define REG_ID        8'h10
`define REG_SYNC      8'h14
`define REG_STACK     8'h20
`define REG_STACK_END 8'h3c

// ==========================================================
// Control bits
`define CTL_FMT  0
`define CTL_RDID 1
`define CTL_ENC  2
`define CTL_LAST 3
`define CTL_STK  4
`define CTL_CMP  5

// ==========================================================
// Status bits and mask bits
`define ST_AM    7
`define ST_XFER  6
`define ST_STOP  4
`define ST_ERR   2
`define ST_LESS  1
`define ST_EQ    0
`define MSK_ERR  3

// ==========================================================
// Reset values
`define FILL_RST 8'h6c
`define SYNC_RST 8'ha1
`define MASK_RST 8'h00

// ==========================================================
// Byte patterns
`define PAT_GAP    8'haa
`define PAT_ZERO   8'h00
`define PAT_MARK   8'h5e
`define PAT_IDSYNC 8'ha1
`define PAT_DSYNC  8'ha0
`define PAT_DID    8'hf8

// ==========================================================
// Field lengths in bytes
`define LEN_ONE    9'h001
`define LEN_LEADING_GAP   9'h00b
`define LEN_PRE    9'h010
`define LEN_HDR    9'h004
`define LEN_CRC    9'h004
`define LEN_IDPOST 9'h006
`define LEN_DATA   9'h100
`define LEN_DPOST  9'h002
`define LEN_RDPOST 9'h002

// ==========================================================
// Check polynomial
`define CRC_POLY 32'h04c11db7
`define CRC_INIT 32'hffffffff

`endif

// ==== hdl/disk_sector_format_sequencer.v ====
/*
 * Disk sector format sequencer: lays out a formatted track (gaps,
 * preambles, marks, sync, ID, check bytes, fill data) and reads back
 * sector IDs with sync hunt, compare, stack and stop on error.
 * Assumes one clock per serial bit, APB register access, and drive
 * pins synchronous to clk.
 */
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "disk_fmt_consts.vh"

module disk_sector_format_sequencer (
	input  wire        clk,
	input  wire        reset_n,
	input  wire [7:0]  paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output wire        irq,
	input  wire        index_pulse,
	input  wire        rd_data,
	input  wire        write_mark_or_mark_detect_n_i,
	output reg         write_mark_or_mark_detect_n_o,
	output reg         write_mark_or_mark_detect_n_oe_n,
	output reg         write_gate,
	output reg         read_gate,
	output reg         wr_data
);

	// ==========================================================
	// States
	localparam [4:0] S_IDLE    = 5'h00;
	localparam [4:0] S_IDX     = 5'h01;
	localparam [4:0] S_LEADING_GAP    = 5'h02;
	localparam [4:0] S_OFF1    = 5'h03;
	localparam [4:0] S_IDPRE   = 5'h04;
	localparam [4:0] S_IDAM    = 5'h05;
	localparam [4:0] S_IDSYN   = 5'h06;
	localparam [4:0] S_HDR     = 5'h07;
	localparam [4:0] S_IDCRC   = 5'h08;
	localparam [4:0] S_IDPOST  = 5'h09;
	localparam [4:0] S_OFF2    = 5'h0a;
	localparam [4:0] S_DPRE    = 5'h0b;
	localparam [4:0] S_DAM     = 5'h0c;
	localparam [4:0] S_DSYN    = 5'h0d;
	localparam [4:0] S_DID     = 5'h0e;
	localparam [4:0] S_DATA    = 5'h0f;
	localparam [4:0] S_DCRC    = 5'h10;
	localparam [4:0] S_DPOST   = 5'h11;
	localparam [4:0] S_TRAILING_GAP    = 5'h12;
	localparam [4:0] S_HUNT    = 5'h13;
	localparam [4:0] S_RHDR    = 5'h14;
	localparam [4:0] S_RCRC    = 5'h15;
	localparam [4:0] S_RPOST   = 5'h16;

	// ==========================================================
	// Declarations
	reg         rst_s1_r, rst_n_r, lock_r, dif_r, less_r, crcerr_r;
	reg         idx_d_r, hit;
	reg  [4:0]  state_r;
	reg  [2:0]  ring_r, ptr_r;
	reg  [8:0]  cnt_r, len;
	reg  [5:2]  ctrl_r;
	reg  [7:0]  rxsh_r, stat_r, mask_r, fill_r, sync_r;
	reg  [7:0]  tx_byte, id_byte, crc_byte;
	reg  [31:0] crc_r, id_r, rd_mux;
	wire [63:0] stk_flat;
	wire [7:0]  rx_now, st_set;
	wire        idx_edge, byte_end, last_byte, amd, push, coder_mark;
	wire        rd_done, rd_fail, wr_en, wr_stat, start_fmt, start_rd;
	wire        in_wg;

	// ==========================================================
	// Reset release
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// ==========================================================
	// Check byte update, MSB first
	function [31:0] crc_upd;
		input [31:0] c;
		input [7:0]  d;
		integer      i;
		reg   [31:0] x;
		begin
			x = c;
			for (i = 0; i < 8; i = i + 1)
				x = {x[30:0], 1'b0}
					^ ((x[31] ^ d[7 - i]) ? `CRC_POLY : 32'h00000000);
			crc_upd = x;
		end
	endfunction

	// ==========================================================
	// Byte framing
	assign idx_edge  = index_pulse & ~idx_d_r;
	assign byte_end  = (ring_r == 3'h7);
	assign last_byte = (cnt_r == len - `LEN_ONE);
	assign rx_now    = {rxsh_r[6:0], rd_data};

	// Internal coder sees the mark on the raw stream
	assign coder_mark = ctrl_r[`CTL_ENC] & ~lock_r & (state_r == S_HUNT)
		& (rx_now == `PAT_MARK);
	assign amd = ctrl_r[`CTL_ENC] ? lock_r
		: ~write_mark_or_mark_detect_n_i;

	assign push    = (state_r == S_RHDR) & byte_end & ctrl_r[`CTL_STK];
	assign rd_done = (state_r == S_RCRC) & byte_end & last_byte;
	// ID mismatch only counts when compare is enabled
	assign rd_fail = rd_done & (crcerr_r | (rx_now != crc_byte)
		| (dif_r & ctrl_r[`CTL_CMP]));

	always @* begin
		case (state_r)
			S_LEADING_GAP:                   len = `LEN_LEADING_GAP;
			S_IDPRE, S_DPRE:          len = `LEN_PRE;
			S_HDR, S_RHDR:            len = `LEN_HDR;
			S_IDCRC, S_DCRC, S_RCRC:  len = `LEN_CRC;
			S_IDPOST:                 len = `LEN_IDPOST;
			S_DATA:                   len = `LEN_DATA;
			S_DPOST:                  len = `LEN_DPOST;
			S_RPOST:                  len = `LEN_RDPOST;
			default:                  len = `LEN_ONE;
		endcase
	end

	// Byte 0 is the most significant byte of each word
	always @* begin
		id_byte  = id_r[{~cnt_r[1:0], 3'h0} +: 8];
		crc_byte = crc_r[{~cnt_r[1:0], 3'h0} +: 8];
	end

	always @* begin
		case (state_r)
			S_LEADING_GAP, S_TRAILING_GAP:   tx_byte = `PAT_GAP;
			S_IDAM, S_DAM:    tx_byte = `PAT_MARK;
			S_IDSYN:          tx_byte = `PAT_IDSYNC;
			S_HDR:            tx_byte = id_byte;
			S_IDCRC, S_DCRC:  tx_byte = crc_byte;
			S_DSYN:           tx_byte = `PAT_DSYNC;
			S_DID:            tx_byte = `PAT_DID;
			S_DATA:           tx_byte = fill_r;
			default:          tx_byte = `PAT_ZERO;
		endcase
	end

	// Gate is off while idle, waiting, reading IDs, or in the one-byte breaks
	assign in_wg = (state_r >= S_LEADING_GAP) & (state_r <= S_TRAILING_GAP)
		& (state_r != S_OFF1) & (state_r != S_OFF2);

	// ==========================================================
	// Sequencer
	always @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r  <= S_IDLE;
			ring_r   <= 3'h0;
			cnt_r    <= 9'h000;
			crc_r    <= `CRC_INIT;
			rxsh_r   <= 8'h00;
			lock_r   <= 1'b0;
			dif_r    <= 1'b0;
			less_r   <= 1'b0;
			crcerr_r <= 1'b0;
			ptr_r    <= 3'h0;
			idx_d_r  <= 1'b0;
		end else begin
			idx_d_r <= index_pulse;
			// Mark byte found by the internal coder never reaches the deserializer
			rxsh_r <= coder_mark ? 8'h00 : rx_now;
			lock_r <= coder_mark | (lock_r & (state_r != S_IDLE));
			case (state_r)
				S_IDLE: begin
					ring_r <= 3'h0;
					cnt_r  <= 9'h000;
					if (start_fmt)
						state_r <= S_IDX;
					else if (start_rd)
						state_r <= S_HUNT;
				end
				S_IDX: begin
					// Hold here until the rising edge of the index pulse
					ring_r <= 3'h0;
					if (idx_edge)
						state_r <= S_LEADING_GAP;
				end
				S_TRAILING_GAP: begin
					ring_r <= ring_r + 3'h1;
					if (idx_edge)
						state_r <= S_IDLE;
				end
				S_HUNT: begin
					// Ring held stopped while hunting
					ring_r <= 3'h0;
					if (amd & (rx_now == sync_r)) begin
						state_r  <= S_RHDR;
						cnt_r    <= 9'h000;
						crc_r    <= `CRC_INIT;
						dif_r    <= 1'b0;
						less_r   <= 1'b0;
						crcerr_r <= 1'b0;
						ptr_r    <= 3'h0;
					end
				end
				default: begin
					ring_r <= ring_r + 3'h1;
					if (byte_end) begin
						case (state_r)
							S_IDAM, S_DID:
								crc_r <= `CRC_INIT;
							S_HDR, S_DATA:
								crc_r <= crc_upd(crc_r, tx_byte);
							S_RHDR: begin
								crc_r <= crc_upd(crc_r, rx_now);
								if (push)
									ptr_r <= ptr_r + 3'h1;
								// First differing byte decides order
								if (~dif_r & (rx_now != id_byte)) begin
									dif_r  <= 1'b1;
									less_r <= rx_now < id_byte;
								end
							end
							S_RCRC:
								if (rx_now != crc_byte)
									crcerr_r <= 1'b1;
							default: ;
						endcase
						if (last_byte) begin
							cnt_r <= 9'h000;
							case (state_r)
								S_DPOST:
									state_r <= ctrl_r[`CTL_LAST] ? S_TRAILING_GAP
										: S_LEADING_GAP;
								S_RCRC:
									state_r <= rd_fail ? S_IDLE
										: S_RPOST;
								S_RPOST:
									state_r <= S_IDLE;
								default:
									state_r <= state_r + 5'h01;
							endcase
						end else begin
							cnt_r <= cnt_r + 9'h001;
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Stack of captured ID bytes
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : gen_stk
			reg [7:0] ent_r;
			always @(posedge clk or negedge rst_n_r) begin
				if (!rst_n_r)
					ent_r <= 8'h00;
				else if (push & (ptr_r == g))
					ent_r <= rx_now;
			end
			assign stk_flat[8 * g +: 8] = ent_r;
		end
	endgenerate

	// ==========================================================
	// Drive pins; data and gate share one cycle of latency
	always @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			wr_data    <= 1'b0;
			write_gate <= 1'b0;
			read_gate  <= 1'b0;
			write_mark_or_mark_detect_n_o    <= 1'b1;
			write_mark_or_mark_detect_n_oe_n <= 1'b1;
		end else begin
			wr_data    <= tx_byte[3'h7 - ring_r];
			write_gate <= in_wg;
			// Gate covers hunt, ID, check bytes and, unless the read fails, two postamble bytes
			read_gate  <= (state_r >= S_HUNT);
			write_mark_or_mark_detect_n_o <= ~((state_r == S_IDAM)
				| (state_r == S_DAM));
			write_mark_or_mark_detect_n_oe_n <= ~in_wg;
		end
	end

	// ==========================================================
	// Status events; set wins over a same-cycle clear
	assign st_set[`ST_AM]   = (state_r == S_IDAM) & byte_end;
	assign st_set[`ST_XFER] = (state_r == S_DID) & byte_end;
	assign st_set[5]        = 1'b0;
	assign st_set[`ST_STOP] = ((state_r == S_TRAILING_GAP) & idx_edge)
		| rd_fail;
	assign st_set[3]        = 1'b0;
	assign st_set[`ST_ERR]  = rd_fail;
	// Compare results posted only after check bytes
	assign st_set[`ST_LESS] = rd_done & less_r;
	assign st_set[`ST_EQ]   = rd_done & ~rd_fail & ctrl_r[`CTL_CMP];

	assign irq = (stat_r[`ST_AM] & mask_r[`ST_AM])
		| (stat_r[`ST_XFER] & mask_r[`ST_XFER])
		| (stat_r[`ST_STOP] & mask_r[`ST_STOP])
		| (stat_r[`ST_ERR] & mask_r[`MSK_ERR])
		| (stat_r[`ST_EQ] & mask_r[`ST_EQ]);

	// ==========================================================
	// APB slave, zero wait states
	assign pready    = 1'b1;
	assign wr_en     = psel & penable & pwrite & hit;
	assign wr_stat   = wr_en & (paddr == `REG_STAT);
	assign start_fmt = wr_en & (paddr == `REG_CTRL) & pwdata[`CTL_FMT];
	assign start_rd  = wr_en & (paddr == `REG_CTRL) & pwdata[`CTL_RDID];
	assign pslverr   = psel & penable & ~hit;

	always @* begin
		hit    = 1'b1;
		rd_mux = 32'h00000000;
		case (paddr)
			`REG_CTRL: rd_mux = {26'h0, ctrl_r, 1'b0, state_r != S_IDLE};
			`REG_STAT: rd_mux = {24'h0, stat_r};
			`REG_MASK: rd_mux = {24'h0, mask_r};
			`REG_FILL: rd_mux = {24'h0, fill_r};
			`REG_ID:   rd_mux = id_r;
			`REG_SYNC: rd_mux = {24'h0, sync_r};
			default:
				if ((paddr >= `REG_STACK) & (paddr <= `REG_STACK_END)
					& (paddr[1:0] == 2'h0))
					rd_mux = {24'h0, stk_flat[{paddr[4:2], 3'h0} +: 8]};
				else
					hit = 1'b0;
		endcase
	end

	always @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			prdata <= 32'h00000000;
			ctrl_r <= 4'h0;
			stat_r <= 8'h00;
			mask_r <= `MASK_RST;
			fill_r <= `FILL_RST;
			id_r   <= 32'h00000000;
			sync_r <= `SYNC_RST;
		end else begin
			if (psel & ~penable)
				prdata <= rd_mux;
			// Unused compare bits are left to software
			if (wr_en)
				case (paddr)
					`REG_CTRL: ctrl_r <= pwdata[5:2];
					`REG_MASK: mask_r <= pwdata[7:0];
					`REG_FILL: fill_r <= pwdata[7:0];
					`REG_ID:   id_r   <= pwdata;
					`REG_SYNC: sync_r <= pwdata[7:0];
					default: ;
				endcase
			stat_r[7:0] <= (stat_r & ~({8{wr_stat}} & pwdata[7:0]))
				| st_set;
			// Mark status drops after the ID check bytes
			if (((state_r == S_IDCRC) & byte_end & last_byte) | rd_done)
				stat_r[`ST_AM] <= 1'b0;
		end
	end

endmodule

// ==== sim/disk_sector_format_sequencer_props.sv ====
/*
 * Port checker for the format sequencer: APB answer, mark byte,
 * write gate spacing and read gate start.
 * Assumes the top module's ports only; attached by bind below.
 */
`timescale 1ns/1ns

module seq_port_checker (
	input wire        clk,
	input wire        reset_n,
	input wire [7:0]  paddr,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        write_mark_or_mark_detect_n_o,
	input wire        write_mark_or_mark_detect_n_oe_n,
	input wire        write_gate,
	input wire        read_gate
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	wire access   = psel && penable;
	wire rd_start = access && pwrite && paddr == 8'h00 && pwdata[1];
	wire mark_o   = write_mark_or_mark_detect_n_o;

	// ==========================================================
	// Sequences
	sequence mark_rest;
		!mark_o [*7] ##1 mark_o;
	endsequence
	sequence gate_off;
		!write_gate [*7];
	endsequence

	// ==========================================================
	// Properties
	chk_ready_zero: assert property (access |-> pready)
		else $error("pready low in an access");
	chk_unmapped_err: assert property
		(access && (paddr == 8'h18 || paddr == 8'h1c) |-> pslverr)
		else $error("no error on unmapped access");
	chk_rdata_hold: assert property (!psel |=> $stable(prdata))
		else $error("read data changed outside a transfer");
	chk_mark_byte: assert property ($fell(mark_o) |=> mark_rest)
		else $error("mark strobe not one byte long");
	chk_mark_gated: assert property (!mark_o |-> write_gate)
		else $error("mark strobe without write gate");
	chk_pin_drive: assert property
		(write_gate |-> !write_mark_or_mark_detect_n_oe_n)
		else $error("mark pin not driven while writing");
	chk_gate_gap: assert property ($fell(write_gate) |=> gate_off)
		else $error("write gate off for less than a byte");
	chk_read_start: assert property
		(rd_start && !write_gate && !read_gate |-> ##[1:2] read_gate)
		else $error("read gate late after start");
	chk_gate_excl: assert property (!(write_gate && read_gate))
		else $error("read and write gate together");
endmodule

bind disk_sector_format_sequencer seq_port_checker chk_u (
	.clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
	.pready, .pslverr, .write_mark_or_mark_detect_n_o,
	.write_mark_or_mark_detect_n_oe_n, .write_gate, .read_gate);

// ==== sim/drive_channel_model.sv ====
/*
 * Drive channel model: captures written bytes with the mark pin level
 * and plays read frames back, one bit per clk, MSB first.
 * Assumes the mark pin idles high when nobody drives it.
 */
`timescale 1ns/1ns

module drive_channel_model (
	input  wire  clk,
	input  wire  write_gate,
	input  wire  wr_data,
	input  wire  mark_pin,
	output logic rd_data,
	output logic mark_n
);
	logic [8:0] cap[$];
	int         segs = 0;
	logic [7:0] sh = 0;
	logic [2:0] nb = 0;
	logic       mk = 0;
	logic       wg_d = 0;
	logic       busy = 0;

	initial begin
		rd_data = 0;
		mark_n = 1;
	end

	// ==========================================================
	// Capture; the byte-long gate gap realigns the bit count
	always @(posedge clk) begin
		wg_d <= write_gate;
		if (write_gate && !wg_d)
			segs++;
		if (!write_gate)
			nb <= 0;
		else begin
			sh = {sh[6:0], wr_data};
			nb <= nb + 3'd1;
			if (nb == 3'd3)
				mk <= !mark_pin;
			if (nb == 3'd7)
				cap.push_back({mk, sh});
		end
	end

	// ==========================================================
	// Playback; idle data toggles so a stale bit never reads as valid
	always @(posedge clk) begin
		if (!busy)
			rd_data <= ~rd_data;
	end

	task automatic play(input logic [8:0] q[$]);
		busy = 1;
		foreach (q[i])
			for (int k = 7; k >= 0; k--) begin
				rd_data <= q[i][k];
				mark_n <= !q[i][8];
				@(posedge clk);
			end
		mark_n <= 1;
		busy = 0;
	endtask
endmodule

// ==== sim/disk_sector_format_sequencer_tb_top.sv ====
/*
 * Bench for the format sequencer: APB tasks, two formatted sectors and
 * three read-ID frames checked against values worked out here.
 * Assumes the constants header and the drive channel model.
 */
`timescale 1ns/1ns
`include "disk_fmt_consts.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end

module disk_sector_format_sequencer_tb_top;
	logic        clk = 0;
	logic        reset_n = 0;
	logic [7:0]  paddr = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [31:0] pwdata = 0;
	logic        index_pulse = 0;
	wire  [31:0] prdata;
	wire         pready, pslverr, irq, rd_data, drv_mark_n;
	wire         mark_o, oe_n, write_gate, read_gate, wr_data;
	wire         mark_pin = oe_n ? drv_mark_n : mark_o;
	int          n_fail = 0;
	int          tests_run = 0;
	logic [31:0] rdat;
	logic        lerr;
	logic [8:0]  exp[$];
	logic [7:0]  hdr[$];
	logic [7:0]  fill[$];

	always #4 clk = ~clk;

	disk_sector_format_sequencer dut_u (
		.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.index_pulse(index_pulse), .rd_data(rd_data),
		.write_mark_or_mark_detect_n_i(mark_pin),
		.write_mark_or_mark_detect_n_o(mark_o),
		.write_mark_or_mark_detect_n_oe_n(oe_n),
		.write_gate(write_gate), .read_gate(read_gate), .wr_data(wr_data));

	drive_channel_model drv_u (
		.clk(clk), .write_gate(write_gate), .wr_data(wr_data),
		.mark_pin(mark_pin), .rd_data(rd_data), .mark_n(drv_mark_n));

	// ==========================================================
	// Tasks
	task summarize;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		// Only the watchdog ends a wait for the answer
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rdat = prdata;
		lerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic pulse_index;
		@(posedge clk);
		index_pulse <= 1;
		repeat (4) @(posedge clk);
		index_pulse <= 0;
	endtask

	function automatic logic [31:0] crc32(input logic [7:0] q[$]);
		logic [31:0] c;
		c = `CRC_INIT;
		foreach (q[i])
			for (int k = 7; k >= 0; k--)
				c = (c << 1) ^ ((c[31] ^ q[i][k]) ? `CRC_POLY : 32'h0);
		return c;
	endfunction

	task automatic add(input int n, input logic [7:0] b, input logic m);
		repeat (n) exp.push_back({m, b});
	endtask

	task automatic addcrc(input logic [7:0] q[$]);
		logic [31:0] c;
		c = crc32(q);
		for (int k = 3; k >= 0; k--)
			add(1, c[8*k +: 8], 1'b0);
	endtask

	// One read-ID frame; st is the expected status under mask 17h
	task automatic rid(input logic [31:0] ctl, input logic [7:0] sec,
			input logic bad, input logic [7:0] st);
		logic [8:0]  q[$];
		logic [7:0]  h[$];
		logic [31:0] c;
		int          n, t;
		h = '{8'h12, 8'h03, sec, 8'h00};
		c = crc32(h) ^ {31'h0, bad};
		q = '{9'h000, 9'h000, 9'h000, ctl[2] ? 9'h05e : 9'h100,
			ctl[2] ? 9'h0a1 : 9'h1a1};
		foreach (h[i])
			q.push_back({1'b0, h[i]});
		for (int k = 3; k >= 0; k--)
			q.push_back({1'b0, c[8*k +: 8]});
		repeat (3) q.push_back(9'h000);
		wr(`REG_CTRL, ctl);
		n = 0;
		while (read_gate !== 1'b1 && n < 10) begin
			@(posedge clk);
			n++;
		end
		`CHK(read_gate, 1'b1)
		t = 0;
		fork
			drv_u.play(q);
			while (read_gate === 1'b1 && t < 200) begin
				@(posedge clk);
				t++;
			end
		join
		t = t - 104;
		`CHK(st[2] ? (t inside {[0:4]}) : (t inside {[14:19]}), 1'b1)
		@(negedge clk);
		`CHK(irq, 1'b1)
		rd(`REG_STAT);
		`CHK(rdat[7:0] & 8'h17, st)
	endtask

	// ==========================================================
	// Tests
	initial begin
		#(8 * 30000);
		n_fail++;
		summarize;
	end

	initial begin
		int n;
		hdr = '{8'h12, 8'h03, 8'h07, 8'h00};
		repeat (256) fill.push_back(8'h3c);
		repeat (2) @(posedge clk);
		reset_n <= 1;
		repeat (3) @(posedge clk);
		rd(`REG_FILL);
		`CHK(rdat, 32'h6c)
		rd(`REG_SYNC);
		`CHK(rdat, 32'ha1)
		rd(8'h18);
		`CHK({lerr, rdat}, 33'h1_0000_0000)
		wr(`REG_MASK, 32'h10);
		wr(`REG_ID, 32'h12030700);
		wr(`REG_FILL, 32'h3c);
		wr(`REG_CTRL, 32'h1);
		repeat (200) @(posedge clk);
		`CHK(write_gate, 1'b0)
		pulse_index;
		n = 0;
		while (drv_u.cap.size() < 400 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		// Second sector is flagged as the last one of the track
		wr(`REG_CTRL, 32'h8);
		n = 0;
		while (drv_u.cap.size() < 654 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		pulse_index;
		n = 0;
		while (write_gate !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		`CHK(n < 100, 1'b1)
		add(11, `PAT_GAP, 0);
		add(16, 8'h00, 0);
		add(1, 8'h5e, 1);
		add(1, 8'ha1, 0);
		foreach (hdr[i])
			add(1, hdr[i], 0);
		addcrc(hdr);
		add(22, 8'h00, 0);
		add(1, 8'h5e, 1);
		add(1, 8'ha0, 0);
		add(1, 8'hf8, 0);
		add(256, 8'h3c, 0);
		addcrc(fill);
		add(2, 8'h00, 0);
		exp = {exp, exp};
		foreach (exp[i])
			`CHK(drv_u.cap[i], exp[i])
		for (int i = exp.size(); i < drv_u.cap.size(); i++)
			`CHK(drv_u.cap[i], 9'h0aa)
		`CHK(drv_u.segs, 5)
		@(negedge clk);
		`CHK(irq, 1'b1)
		rd(`REG_STAT);
		`CHK(rdat[7:0] & 8'hd0, 8'h50)
		wr(`REG_STAT, 32'hff);
		wr(`REG_MASK, 32'h19);
		wr(`REG_SYNC, 32'ha1);
		rid(32'h32, 8'h07, 1'b0, 8'h01);
		for (int i = 0; i < 4; i++) begin
			rd(`REG_STACK + 8'(4 * i));
			`CHK(rdat, {24'h0, hdr[i]})
		end
		wr(`REG_STAT, 32'hff);
		rid(32'h22, 8'h05, 1'b0, 8'h16);
		wr(`REG_STAT, 32'hff);
		rid(32'h06, 8'h07, 1'b1, 8'h14);
		wr(`REG_STAT, 32'hff);
		@(negedge clk);
		`CHK(irq, 1'b0)
		summarize;
	end
endmodule
